// *** src/polseq_pkg.sv ***
package polseq_pkg;
  localparam int DAC_W      = 12;
  localparam int CNT_W      = 16;
  localparam int ADDR_W     = 7;
  localparam int CLK_MHZ    = 125;
  localparam int TICK_US    = 10;
  localparam int TICK_CYC   = TICK_US * CLK_MHZ;
  localparam int MAX_RATE_HZ = 10000;
  localparam int MIN_CORR_TICKS = 1000000 / (MAX_RATE_HZ * TICK_US);
  localparam logic [DAC_W-1:0] DAC_ZERO = 12'h000;
  localparam logic [DAC_W-1:0] DAC_LSB  = 12'h001;
  typedef enum logic [2:0] {
    POLSEQ_OFF, POLSEQ_ON_DLY, POLSEQ_RISE, POLSEQ_REG,
    POLSEQ_OFF_DLY, POLSEQ_FALL
  } polseq_state_t;
endpackage

// *** src/polseq_top.sv ***
module polseq_top (
  input  wire logic                           i_clk_sys,
  input  wire logic                           i_nrst,
  input  wire logic                           i_cmd_on,
  input  wire logic                           i_cmd_off,
  input  wire logic                           i_addr_onoff_pin,
  input  wire logic                           i_pin_control,
  input  wire logic                           i_feedback_node_mode,
  input  wire logic [polseq_pkg::DAC_W-1:0]   i_target_voltage_setting,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_ton_delay,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_ton_rise,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_toff_delay,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_toff_fall,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_trim_update_rate,
  input  wire logic [polseq_pkg::CNT_W-1:0]   i_margin_slew_setting,
  input  wire logic [3:0]                     i_divider_ratio_setting,
  input  wire logic [polseq_pkg::DAC_W-1:0]   i_sense_plus,
  input  wire logic [polseq_pkg::DAC_W-1:0]   i_sense_minus,
  input  wire logic                           i_sense_valid,
  input  wire logic [polseq_pkg::DAC_W-1:0]   i_dac_pin_meas,
  input  wire logic [polseq_pkg::ADDR_W-1:0]  i_bus_addr_sel,
  output logic [polseq_pkg::DAC_W-1:0]        o_trim_dac_out,
  output logic                                o_dac_connect_switch,
  output logic                                o_power_enable_out,
  output logic                                o_power_enable_oe_n,
  output logic [polseq_pkg::ADDR_W-1:0]       o_bus_addr,
  output logic [1:0]                          o_phase
);
  import polseq_pkg::*;

  // ****************************************
  // pin synchroniser and commands
  // ****************************************
  logic                pin_s1_reg;
  logic                pin_s2_reg;
  logic                pin_d_reg;
  logic                want_on;
  logic                want_off;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pin_s1_reg <= 1'b0;
      pin_s2_reg <= 1'b0;
      pin_d_reg  <= 1'b0;
    end else begin
      pin_s1_reg <= i_addr_onoff_pin;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg  <= pin_s2_reg;
    end
  end
  // command source chosen by pin control setting
  assign want_on  = i_pin_control ? (pin_s2_reg & ~pin_d_reg)
                                  : i_cmd_on;
  assign want_off = i_pin_control ? (~pin_s2_reg & pin_d_reg)
                                  : i_cmd_off;

  // ****************************************
  // time base
  // ****************************************
  logic [15:0] pre_reg;
  logic        tick_reg;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      pre_reg  <= 16'h0000;
      tick_reg <= 1'b0;
    end else if (pre_reg == 16'(TICK_CYC - 1)) begin
      pre_reg  <= 16'h0000;
      tick_reg <= 1'b1;
    end else begin
      pre_reg  <= pre_reg + 16'h0001;
      tick_reg <= 1'b0;
    end
  end

  // ****************************************
  // sequencer
  // ****************************************
  polseq_state_t       state_reg;
  logic [CNT_W-1:0]    cnt_reg;
  logic [CNT_W-1:0]    step_reg;
  logic [DAC_W-1:0]    dac_reg;
  logic [DAC_W-1:0]    goal_reg;
  logic [DAC_W-1:0]    sense;
  logic [CNT_W-1:0]    corr_reg;
  logic                done;
  logic                at_goal;

  assign done    = tick_reg && (cnt_reg == '0);
  assign at_goal = (dac_reg == goal_reg);
  assign sense   = i_sense_plus - i_sense_minus;

  // ticks per dac step so a ramp of ticks finishes on the target
  function automatic logic [CNT_W-1:0] step_ticks(
    input logic [CNT_W-1:0] t, input logic [DAC_W-1:0] span,
    input logic [3:0] div);
    logic [CNT_W+3:0] sc;
    logic [CNT_W+3:0] q;
    sc = {4'h0, t} << div;
    q  = (span == '0) ? sc : sc / {{(CNT_W-DAC_W+4){1'b0}}, span};
    step_ticks = (q == '0) ? '0 : CNT_W'(q - 1'b1);
  endfunction

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      state_reg <= POLSEQ_OFF;
      cnt_reg   <= '0;
      step_reg  <= '0;
      goal_reg  <= DAC_ZERO;
      o_phase   <= 2'b00;
    end else begin
      unique case (state_reg)
        POLSEQ_OFF: begin
          if (want_on) begin
            state_reg <= POLSEQ_ON_DLY;
            cnt_reg   <= i_ton_delay;
            o_phase   <= 2'b01;
          end
        end
        POLSEQ_ON_DLY: begin
          if (want_off) begin
            state_reg <= POLSEQ_OFF;
            o_phase   <= 2'b00;
          end else if (done) begin
            state_reg <= POLSEQ_RISE;
            cnt_reg   <= i_ton_rise;
            goal_reg  <= i_target_voltage_setting;
            step_reg  <= step_ticks(i_ton_rise,
                           i_target_voltage_setting, i_divider_ratio_setting);
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        POLSEQ_RISE: begin
          if (done) begin
            state_reg <= POLSEQ_REG;
            o_phase   <= 2'b10;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        POLSEQ_REG: begin
          if (want_off) begin
            state_reg <= POLSEQ_OFF_DLY;
            cnt_reg   <= i_toff_delay;
            o_phase   <= 2'b11;
          end else if (i_target_voltage_setting != goal_reg) begin
            goal_reg <= i_target_voltage_setting;
            step_reg <= i_feedback_node_mode ? '0 : i_margin_slew_setting;
          end
        end
        POLSEQ_OFF_DLY: begin
          if (done) begin
            if (i_feedback_node_mode) begin
              state_reg <= POLSEQ_OFF;
              o_phase   <= 2'b00;
            end else begin
              state_reg <= POLSEQ_FALL;
              cnt_reg   <= i_toff_fall;
              goal_reg  <= DAC_ZERO;
              step_reg  <= step_ticks(i_toff_fall, dac_reg,
                                      i_divider_ratio_setting);
            end
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        POLSEQ_FALL: begin
          if (done) begin
            state_reg <= POLSEQ_OFF;
            o_phase   <= 2'b00;
          end else if (tick_reg) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
        default: state_reg <= POLSEQ_OFF;
      endcase
    end
  end

  // ****************************************
  // dac ramp and trim
  // ****************************************
  logic        ramping;
  logic        corr_due;
  logic        margin_reg;
  // margin ramp runs only until the dac meets the new goal
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      margin_reg <= 1'b0;
    end else if (state_reg != POLSEQ_REG || i_feedback_node_mode) begin
      margin_reg <= 1'b0;
    end else if (i_target_voltage_setting != goal_reg) begin
      margin_reg <= 1'b1;
    end else if (at_goal) begin
      margin_reg <= 1'b0;
    end
  end
  assign ramping  = !i_feedback_node_mode &&
                    (state_reg == POLSEQ_RISE || state_reg == POLSEQ_FALL ||
                     (state_reg == POLSEQ_REG && margin_reg));
  assign corr_due = tick_reg && (corr_reg == '0);

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      corr_reg <= '0;
    end else if (corr_due) begin
      corr_reg <= (i_trim_update_rate < CNT_W'(MIN_CORR_TICKS))
                  ? CNT_W'(MIN_CORR_TICKS - 1)
                  : i_trim_update_rate - 1'b1;
    end else if (tick_reg) begin
      corr_reg <= corr_reg - 1'b1;
    end
  end

  logic [CNT_W-1:0] pace_reg;
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      dac_reg  <= DAC_ZERO;
      pace_reg <= '0;
    end else if (state_reg == POLSEQ_OFF) begin
      dac_reg  <= DAC_ZERO;
      pace_reg <= '0;
    end else if (state_reg == POLSEQ_RISE && i_feedback_node_mode) begin
      if (done)
        dac_reg <= i_dac_pin_meas;
    end else if (ramping) begin
      if (state_reg != POLSEQ_REG && done) begin
        dac_reg <= goal_reg;
      end else if (tick_reg && !at_goal) begin
        if (pace_reg == '0) begin
          pace_reg <= step_reg;
          dac_reg  <= (goal_reg > dac_reg) ? dac_reg + DAC_LSB
                                           : dac_reg - DAC_LSB;
        end else begin
          pace_reg <= pace_reg - 1'b1;
        end
      end
    end else if (state_reg == POLSEQ_REG && corr_due && i_sense_valid) begin
      // feedback mode margins here too, slew ignored
      if (sense < goal_reg && dac_reg != 12'hFFF)
        dac_reg <= dac_reg + DAC_LSB;
      else if (sense > goal_reg && dac_reg != DAC_ZERO)
        dac_reg <= dac_reg - DAC_LSB;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      o_trim_dac_out       <= DAC_ZERO;
      o_dac_connect_switch <= 1'b0;
      o_power_enable_out   <= 1'b0;
      o_power_enable_oe_n  <= 1'b0;
      o_bus_addr           <= '0;
    end else begin
      o_trim_dac_out <= dac_reg;
      // released during feedback rise
      o_dac_connect_switch <= !(state_reg == POLSEQ_OFF ||
                                state_reg == POLSEQ_ON_DLY ||
                                (state_reg == POLSEQ_RISE &&
                                 i_feedback_node_mode));
      // enable active in rise, regulate, off delay and fall
      o_power_enable_out  <= (state_reg != POLSEQ_OFF &&
                              state_reg != POLSEQ_ON_DLY);
      // open drain: pull low (oe_n low) while off
      o_power_enable_oe_n <= (state_reg != POLSEQ_OFF &&
                              state_reg != POLSEQ_ON_DLY);
      o_bus_addr <= (i_bus_addr_sel == '0) ? 7'h01 : i_bus_addr_sel;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  sequence s_fall_end;
    state_reg == POLSEQ_FALL && done;
  endsequence
  a_fall_to_zero: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    s_fall_end |=> dac_reg == DAC_ZERO ##1 !o_power_enable_out)
    else $error("ramp down did not end at zero before disable");
  a_fb_release: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_RISE && i_feedback_node_mode
      |=> !o_dac_connect_switch)
    else $error("switch closed during feedback rise");
  a_fb_capture: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_RISE && i_feedback_node_mode && done
      |=> dac_reg == $past(i_dac_pin_meas))
    else $error("dac not loaded from pin measure");
  a_rise_target: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_RISE && !i_feedback_node_mode && done
      |=> dac_reg == goal_reg ##1 o_trim_dac_out == $past(goal_reg))
    else $error("ramp did not reach target");
  a_one_lsb: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_REG && $past(state_reg) == POLSEQ_REG
      && !$changed(goal_reg) |-> dac_reg - $past(dac_reg) inside
      {12'h000, 12'h001, 12'hFFF})
    else $error("trim moved more than one lsb");
  a_start_on: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_OFF && want_on |=> state_reg == POLSEQ_ON_DLY)
    else $error("on request not taken");
  a_fb_off: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_OFF_DLY && done && i_feedback_node_mode
      |=> ##1 !o_power_enable_out)
    else $error("feedback turn-off slow");
  a_en_after_dly: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    state_reg == POLSEQ_ON_DLY && !done |=> !o_power_enable_out)
    else $error("enable before delay");
  a_pace_min: assert property (@(posedge i_clk_sys) disable iff (!i_nrst)
    corr_due |=> corr_reg >= CNT_W'(MIN_CORR_TICKS - 1))
    else $error("correction faster than limit");
endmodule

// *** sim/polseq_pol_model.sv ***
// ****************************************
// supply model: follows dac plus BIAS one cycle later, no soft-start
// ****************************************
module polseq_pol_model
  import polseq_pkg::*;
#(
  parameter logic [11:0] FB_CODE = 12'h3A5,
  parameter logic [11:0] BIAS    = 12'h001
) (
  input  wire logic                         i_clk_sys,
  input  wire logic                         i_enable_line,
  input  wire logic                         i_fb_mode,
  input  wire logic                         i_dac_connect_switch,
  input  wire logic [polseq_pkg::DAC_W-1:0] i_trim_dac_out,
  output logic      [polseq_pkg::DAC_W-1:0] o_sense_plus,
  output logic      [polseq_pkg::DAC_W-1:0] o_sense_minus,
  output logic                              o_sense_valid,
  output logic      [polseq_pkg::DAC_W-1:0] o_dac_pin_meas
);
  import polseq_pkg::*;
  logic [DAC_W-1:0] node;
  // released dac pin shows the feedback node
  assign node = (i_fb_mode && !i_dac_connect_switch) ? FB_CODE
                                                     : i_trim_dac_out;
  initial begin
    o_sense_plus   = 12'h000;
    o_sense_minus  = 12'h000;
    o_sense_valid  = 1'b0;
    o_dac_pin_meas = 12'h000;
  end
  always @(posedge i_clk_sys) begin
    o_sense_plus   <= i_enable_line ? node + BIAS : 12'h000;
    o_sense_valid  <= i_enable_line;
    o_dac_pin_meas <= i_enable_line ? node : 12'h000;
  end
endmodule

// *** sim/testbench.sv ***
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import polseq_pkg::*;
  localparam int TICK = TICK_CYC;
  localparam logic [11:0] TARGET = 12'h2C0;
  localparam logic [11:0] FBC    = 12'h3A5;
  logic             clk_sys, nrst, cmd_on, cmd_off, pin, pin_ctl, fb_mode;
  logic             sv, sw, en, en_oe_n, en_wire, en_prev;
  logic [DAC_W-1:0] tgt, sp, sm, meas, dac, dac_prev;
  logic [CNT_W-1:0] dly, ramp;
  logic [ADDR_W-1:0] addr_sel, bus_addr;
  logic [1:0]       phase, phase_prev, phase_prev2;
  int               err_count, num_checks, waited;
  // released open-drain line is pulled up
  assign en_wire = en_oe_n;
  polseq_top u_dut (
    .i_clk_sys(clk_sys), .i_nrst(nrst), .i_cmd_on(cmd_on),
    .i_cmd_off(cmd_off), .i_addr_onoff_pin(pin), .i_pin_control(pin_ctl),
    .i_feedback_node_mode(fb_mode), .i_target_voltage_setting(tgt),
    .i_ton_delay(dly), .i_ton_rise(ramp), .i_toff_delay(dly),
    .i_toff_fall(ramp), .i_trim_update_rate(16'h000A),
    .i_margin_slew_setting(16'h0001), .i_divider_ratio_setting(4'h0),
    .i_sense_plus(sp), .i_sense_minus(sm), .i_sense_valid(sv),
    .i_dac_pin_meas(meas), .i_bus_addr_sel(addr_sel),
    .o_trim_dac_out(dac), .o_dac_connect_switch(sw),
    .o_power_enable_out(en), .o_power_enable_oe_n(en_oe_n),
    .o_bus_addr(bus_addr), .o_phase(phase));
  polseq_pol_model #(.FB_CODE(FBC), .BIAS(12'h001)) u_pol (
    .i_clk_sys(clk_sys), .i_enable_line(en_wire), .i_fb_mode(fb_mode),
    .i_dac_connect_switch(sw), .i_trim_dac_out(dac), .o_sense_plus(sp),
    .o_sense_minus(sm), .o_sense_valid(sv), .o_dac_pin_meas(meas));
  // ****************************************
  // tasks
  // ****************************************
  task automatic check(input string name, input logic [11:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic complete_run;
    if (err_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  function automatic logic [11:0] probe(input int sel);
    case (sel)
      0: return {10'h000, phase};
      1: return {11'h000, en_wire};
      default: return dac;
    endcase
  endfunction
  task automatic wait_for(input string name, input int sel,
                          input logic [11:0] v, input int ticks);
    int n;
    n = 0;
    while (probe(sel) !== v && n < ticks * TICK) begin
      @(negedge clk_sys);
      n++;
    end
    waited = n;
    check(name, probe(sel), v);
  endtask
  task automatic pulse(input logic on);
    @(posedge clk_sys);
    cmd_on  <= on;
    cmd_off <= !on;
    @(posedge clk_sys);
    cmd_on  <= 1'b0;
    cmd_off <= 1'b0;
    repeat (3) @(negedge clk_sys);
  endtask
  // ****************************************
  // monitors and watchdog
  // ****************************************
  always @(negedge clk_sys) begin
    if (en_prev === 1'b1 && en_wire === 1'b0 && !fb_mode)
      check("dac_at_disable", dac, DAC_ZERO);
    if (fb_mode && phase === 2'h1)
      check("switch_in_rise", {11'h000, sw}, 12'h000);
    if (phase === 2'h2 && phase_prev === 2'h2 && phase_prev2 === 2'h2 &&
        dac !== dac_prev)
      check("trim_step", (dac > dac_prev) ? dac - dac_prev
                                          : dac_prev - dac, DAC_LSB);
    en_prev    <= en_wire;
    dac_prev   <= dac;
    phase_prev <= phase;
    phase_prev2 <= phase_prev;
  end
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (98000) @(posedge clk_sys);
    err_count++;
    complete_run;
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    {nrst, cmd_on, cmd_off, pin, pin_ctl, fb_mode} = 6'h00;
    tgt = TARGET;
    dly = 16'h0002;
    ramp = 16'h0004;
    addr_sel = 7'h00;
    repeat (6) @(posedge clk_sys);
    nrst <= 1'b1;
    @(negedge clk_sys);
    check("dac_reset", dac, DAC_ZERO);
    repeat (3) @(negedge clk_sys);
    check("bus_addr_zero", {5'h00, bus_addr}, 12'h001);
    @(posedge clk_sys);
    addr_sel <= 7'h7F;
    repeat (3) @(negedge clk_sys);
    check("bus_addr_top", {5'h00, bus_addr}, 12'h07F);
    pulse(1'b1);
    check("phase_on", {10'h000, phase}, 12'h001);
    check("en_delay", {11'h000, en_wire}, 12'h000);
    wait_for("phase_reg", 0, 12'h002, 9);
    @(negedge clk_sys);
    check("dac_target", dac, TARGET);
    check("en_active", {11'h000, en_wire}, 12'h001);
    wait_for("trim_down", 2, TARGET - 12'h001, 30);
    check("trim_pace", {11'h000, waited <= 11 * TICK}, 12'h001);
    repeat (2 * TICK) @(negedge clk_sys);
    check("trim_hold", dac, TARGET - 12'h001);
    @(posedge clk_sys);
    tgt <= TARGET + 12'h004;
    wait_for("margin_up", 2, TARGET + 12'h003, 9);
    check("margin_pace", {11'h000, waited >= 5 * TICK}, 12'h001);
    pulse(1'b0);
    wait_for("phase_off", 0, 12'h000, 10);
    @(negedge clk_sys);
    check("dac_off", dac, DAC_ZERO);
    @(posedge clk_sys);
    fb_mode <= 1'b1;
    pin_ctl <= 1'b1;
    tgt <= TARGET;
    @(posedge clk_sys);
    pin <= 1'b1;
    wait_for("fb_en", 1, 12'h001, 5);
    wait_for("fb_reg", 0, 12'h002, 7);
    @(negedge clk_sys);
    check("fb_switch", {11'h000, sw}, 12'h001);
    check("fb_capture", dac, FBC);
    wait_for("fb_trim", 2, FBC - 12'h001, 12);
    wait_for("fb_pace", 2, FBC - 12'h002, 12);
    check("fb_pace_min", {11'h000, waited >= 9 * TICK}, 12'h001);
    @(posedge clk_sys);
    pin <= 1'b0;
    wait_for("fb_disable", 1, 12'h000, 4);
    check("fb_no_ramp", {11'h000, waited < 4 * TICK}, 12'h001);
    check("fb_dac_held", {11'h000, dac != DAC_ZERO}, 12'h001);
    complete_run;
  end
endmodule
